// File: common/ccirq_pkg.sv
// Package: register map, field positions and carrier types of the comparator control block
`default_nettype none
package ccirq_pkg;
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_PIN_DISABLE = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h00c;

  localparam int BIT_POWER_OFF  = 7;
  localparam int BIT_BANDGAP    = 6;
  localparam int BIT_RESULT     = 5;
  localparam int BIT_IRQ_FLAG   = 4;
  localparam int BIT_IRQ_ENABLE = 3;
  localparam int BIT_CAPTURE    = 2;
  localparam int BIT_MODE_HI    = 1;
  localparam int BIT_MODE_LO    = 0;
  localparam int BIT_NEG_OFF    = 1;
  localparam int BIT_POS_OFF    = 0;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [1:0] PINDIS_RESET = 2'h0;
  localparam logic [1:0] EVT_RESET    = 2'h0;

  // Event status bits: edge event, and a change of the power-off bit
  localparam int EVT_EDGE  = 0;
  localparam int EVT_RESVD = 1;

  localparam logic [1:0] MODE_TOGGLE  = 2'h0;
  localparam logic [1:0] MODE_RESVD   = 2'h1;
  localparam logic [1:0] MODE_FALLING = 2'h2;
  localparam logic [1:0] MODE_RISING  = 2'h3;

  typedef struct packed {
    logic       power_off;
    logic       bandgap_select;
    logic       irq_enable;
    logic       capture_route;
    logic [1:0] irq_mode;
  } ccirq_ctrl_t;

  typedef struct packed {
    logic neg_pin_buffer_off;
    logic pos_pin_buffer_off;
  } ccirq_pindis_t;
endpackage : ccirq_pkg
`default_nettype wire

// File: logic/ccirq_sync.sv
// Two-stage synchroniser for the comparator result
`default_nettype none
module ccirq_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Data
  input  wire logic d_in,
  output logic      q_out
);
  logic stage1_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= 1'b0;
      q_out      <= 1'b0;
    end else begin
      stage1_reg <= d_in;
      q_out      <= stage1_reg;
    end
  end
endmodule : ccirq_sync
`default_nettype wire

// File: logic/ccirq_edge.sv
// Edge classifier: compares the synchronised result with its previous value
`default_nettype none
module ccirq_edge (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Level in, mode select, event out
  input  wire logic       level,
  input  wire logic [1:0] mode,
  output logic            hit,
  output logic            prev_level
);
  logic rise;
  logic fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= level;
    end
  end

  assign rise = level & ~prev_level;
  assign fall = ~level & prev_level;

  always_comb begin
    unique case (mode)
      ccirq_pkg::MODE_TOGGLE:  hit = rise | fall;
      ccirq_pkg::MODE_FALLING: hit = fall;
      ccirq_pkg::MODE_RISING:  hit = rise;
      default:                 hit = 1'b0;
    endcase
  end
endmodule : ccirq_edge
`default_nettype wire

// File: logic/ccirq_top.sv
// Comparator control, status and interrupt logic with APB register access
//
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
module ccirq_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Analog comparator core
  input  wire logic        cmp_core_out,
  output logic             cmp_power_off,
  output logic             cmp_bandgap_select,
  // Comparator pins, digital side
  input  wire logic        cmp_pos_pin_digital,
  input  wire logic        cmp_neg_pin_digital,
  output logic             pos_pin_buffer_off,
  output logic             neg_pin_buffer_off,
  output logic             cmp_pos_port_in,
  output logic             cmp_neg_port_in,
  // Processor interrupt
  input  wire logic        cpu_global_irq_enable,
  input  wire logic        cmp_irq_vector_ack,
  output logic             cmp_irq_request,
  output logic             irq,
  // Timer capture front end
  output logic             timer_capture_src
);
  ccirq_pkg::ccirq_ctrl_t   ctrl_reg;
  ccirq_pkg::ccirq_ctrl_t   ctrl_next;
  ccirq_pkg::ccirq_pindis_t pindis_reg;
  ccirq_pkg::ccirq_pindis_t pindis_next;
  logic                     flag_reg;
  logic                     flag_next;
  logic [1:0]               evt_reg;
  logic [1:0]               evt_next;
  logic [1:0]               mask_reg;
  logic [1:0]               mask_next;

  logic        cmp_result;
  logic        edge_hit;
  logic        wr_en;
  logic        rd_en;
  logic        sel_ctrl;
  logic        sel_pindis;
  logic        sel_evt;
  logic        sel_mask;
  logic        addr_hit;
  logic        flag_clear;
  logic [7:0]  ctrl_view;
  logic [31:0] rd_mux;
  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;
  logic [1:0]  evt_set;
  logic [1:0]  evt_clear;
  logic        pwr_event;
  logic        pos_port_next;
  logic        neg_port_next;
  logic        irq_req_next;
  logic        irq_next;
  logic        capture_next;

  // Reset image taken field by field, so the result bit cannot shift the others
  localparam ccirq_pkg::ccirq_ctrl_t CTRL_INIT = '{
    power_off:      ccirq_pkg::CTRL_RESET[ccirq_pkg::BIT_POWER_OFF],
    bandgap_select: ccirq_pkg::CTRL_RESET[ccirq_pkg::BIT_BANDGAP],
    irq_enable:     ccirq_pkg::CTRL_RESET[ccirq_pkg::BIT_IRQ_ENABLE],
    capture_route:  ccirq_pkg::CTRL_RESET[ccirq_pkg::BIT_CAPTURE],
    irq_mode:       ccirq_pkg::CTRL_RESET[ccirq_pkg::BIT_MODE_HI:ccirq_pkg::BIT_MODE_LO]
  };

  // Field map must fit the 8-bit register image
  if (ccirq_pkg::BIT_POWER_OFF >= $bits(ctrl_view)) begin : g_map_chk
    $error("control field map does not fit the register byte");
  end

  // Comparator result into pclk domain
  ccirq_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (cmp_core_out),
    .q_out   (cmp_result)
  );

  ccirq_edge u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .level      (cmp_result),
    .mode       (ctrl_reg.irq_mode),
    .hit        (edge_hit),
    .prev_level ()
  );

  // APB decode; zero-wait-state slave
  assign wr_en      = psel & penable & pwrite;
  assign rd_en      = psel & ~penable & ~pwrite;
  assign sel_ctrl   = (paddr == ccirq_pkg::ADDR_CTRL_STATUS);
  assign sel_pindis = (paddr == ccirq_pkg::ADDR_PIN_DISABLE);
  assign sel_evt    = (paddr == ccirq_pkg::ADDR_IRQ_STATUS);
  assign sel_mask   = (paddr == ccirq_pkg::ADDR_IRQ_MASK);
  assign addr_hit   = sel_ctrl | sel_pindis | sel_evt | sel_mask;

  // Control; result bit is not writable
  assign ctrl_next = (wr_en && sel_ctrl) ? ccirq_pkg::ccirq_ctrl_t'{
      power_off:      pwdata[ccirq_pkg::BIT_POWER_OFF],
      bandgap_select: pwdata[ccirq_pkg::BIT_BANDGAP],
      irq_enable:     pwdata[ccirq_pkg::BIT_IRQ_ENABLE],
      capture_route:  pwdata[ccirq_pkg::BIT_CAPTURE],
      irq_mode:       pwdata[ccirq_pkg::BIT_MODE_HI:ccirq_pkg::BIT_MODE_LO]}
    : ctrl_reg;

  assign pindis_next = (wr_en && sel_pindis) ? ccirq_pkg::ccirq_pindis_t'{
      neg_pin_buffer_off: pwdata[ccirq_pkg::BIT_NEG_OFF],
      pos_pin_buffer_off: pwdata[ccirq_pkg::BIT_POS_OFF]}
    : pindis_reg;

  // Set wins over clear, both from software and the vector acknowledge
  assign flag_clear = cmp_irq_vector_ack | (wr_en & sel_ctrl & pwdata[ccirq_pkg::BIT_IRQ_FLAG]);
  assign flag_next  = edge_hit | (flag_reg & ~flag_clear);

  // Interrupt status: edge event and power-off toggle (spurious-risk indicator)
  assign pwr_event = ctrl_next.power_off ^ ctrl_reg.power_off;
  assign evt_set   = {pwr_event, edge_hit};
  assign evt_clear = (wr_en && sel_evt) ? pwdata[1:0] : 2'h0;
  assign evt_next  = evt_set | (evt_reg & ~evt_clear);
  assign mask_next = (wr_en && sel_mask) ? pwdata[1:0] : mask_reg;

  assign ctrl_view = {ctrl_reg.power_off, ctrl_reg.bandgap_select, cmp_result, flag_reg,
                      ctrl_reg.irq_enable, ctrl_reg.capture_route, ctrl_reg.irq_mode};

  assign rd_mux = sel_ctrl   ? {24'h000000, ctrl_view} :
                  sel_pindis ? {30'h00000000, pindis_reg} :
                  sel_evt    ? {30'h00000000, evt_reg} :
                  sel_mask   ? {30'h00000000, mask_reg} : 32'h00000000;

  // Next values of the registered outputs
  assign pready_next   = psel & ~penable;
  assign pslverr_next  = psel & ~penable & ~addr_hit;
  assign prdata_next   = rd_en ? rd_mux : prdata;
  assign pos_port_next = cmp_pos_pin_digital & ~pindis_next.pos_pin_buffer_off;
  assign neg_port_next = cmp_neg_pin_digital & ~pindis_next.neg_pin_buffer_off;
  assign irq_req_next  = flag_next & ctrl_next.irq_enable & cpu_global_irq_enable;
  assign irq_next      = |(evt_next & mask_next);
  // Synchronised level feeds the capture front end; it does its own filtering
  assign capture_next  = cmp_result & ctrl_next.capture_route;

  // Register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_INIT;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pindis_reg <= ccirq_pkg::ccirq_pindis_t'(ccirq_pkg::PINDIS_RESET);
    end else begin
      pindis_reg <= pindis_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= ccirq_pkg::CTRL_RESET[ccirq_pkg::BIT_IRQ_FLAG];
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= ccirq_pkg::EVT_RESET;
    end else begin
      evt_reg <= evt_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= ccirq_pkg::EVT_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // APB answer registered in setup, so the access phase completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_next;
    end
  end

  // Outputs, each straight from its own flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_power_off <= CTRL_INIT.power_off;
    end else begin
      cmp_power_off <= ctrl_next.power_off;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_bandgap_select <= CTRL_INIT.bandgap_select;
    end else begin
      cmp_bandgap_select <= ctrl_next.bandgap_select;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_pin_buffer_off <= 1'b0;
    end else begin
      pos_pin_buffer_off <= pindis_next.pos_pin_buffer_off;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_pin_buffer_off <= 1'b0;
    end else begin
      neg_pin_buffer_off <= pindis_next.neg_pin_buffer_off;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pos_port_in <= 1'b0;
    end else begin
      cmp_pos_port_in <= pos_port_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_neg_port_in <= 1'b0;
    end else begin
      cmp_neg_port_in <= neg_port_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_irq_request <= 1'b0;
    end else begin
      cmp_irq_request <= irq_req_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_capture_src <= 1'b0;
    end else begin
      timer_capture_src <= capture_next;
    end
  end
endmodule : ccirq_top
`default_nettype wire

// File: testbench/ccirq_core_model.sv
// Partner model: analog comparator core decision
`default_nettype none
module ccirq_core_model #(
  parameter int BANDGAP_MV = 1100
) (
  // Controls from the block
  input  wire logic cmp_power_off,
  input  wire logic cmp_bandgap_select,
  // Input levels in millivolts
  input  var  int   pos_mv,
  input  var  int   neg_mv,
  // Decision
  output logic      cmp_core_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int plus_mv;
  assign plus_mv = cmp_bandgap_select ? BANDGAP_MV : pos_mv;
  // Unpowered core gives no decision, modelled as low
  assign cmp_core_out = !cmp_power_off && (plus_mv > neg_mv);
endmodule : ccirq_core_model
`default_nettype wire

// File: testbench/ccirq_top_sva.sv
// Checker: port-level assertions of the comparator control block
`default_nettype none
module ccirq_top_sva (
  // APB slave
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Comparator side
  input wire logic        cmp_power_off,
  input wire logic        cmp_bandgap_select,
  input wire logic        pos_pin_buffer_off,
  input wire logic        cmp_pos_port_in,
  input wire logic        cpu_global_irq_enable,
  input wire logic        cmp_irq_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_done = psel && penable && pwrite && pready;
  wire logic mapped  = paddr inside {ccirq_pkg::ADDR_CTRL_STATUS, ccirq_pkg::ADDR_PIN_DISABLE,
                                     ccirq_pkg::ADDR_IRQ_STATUS, ccirq_pkg::ADDR_IRQ_MASK};
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without error");
  power_write_a: assert property (wr_done && paddr == ccirq_pkg::ADDR_CTRL_STATUS
    |=> cmp_power_off == $past(pwdata[7])) else $error("power-off not written");
  bandgap_write_a: assert property (wr_done && paddr == ccirq_pkg::ADDR_CTRL_STATUS
    |=> cmp_bandgap_select == $past(pwdata[6])) else $error("bandgap select not written");
  disable_write_a: assert property (wr_done && paddr == ccirq_pkg::ADDR_PIN_DISABLE
    |=> pos_pin_buffer_off == $past(pwdata[0])) else $error("buffer-off not written");
  pos_forced_a: assert property (pos_pin_buffer_off && $past(pos_pin_buffer_off)
    |-> !cmp_pos_port_in) else $error("port input not forced low");
  global_gate_a: assert property (!cpu_global_irq_enable |=> !cmp_irq_request)
    else $error("request without global enable");
endmodule : ccirq_top_sva
bind ccirq_top ccirq_top_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .cmp_power_off, .cmp_bandgap_select, .pos_pin_buffer_off,
  .cmp_pos_port_in, .cpu_global_irq_enable, .cmp_irq_request);
`default_nettype wire

// File: testbench/ccirq_top_tb.sv
// Testbench: register-level tests of the comparator control block
`default_nettype none
module ccirq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CS = ccirq_pkg::ADDR_CTRL_STATUS;
  localparam logic [11:0] PD = ccirq_pkg::ADDR_PIN_DISABLE;
  localparam logic [11:0] IS = ccirq_pkg::ADDR_IRQ_STATUS;
  localparam logic [11:0] IM = ccirq_pkg::ADDR_IRQ_MASK;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cmp_core_out, cmp_power_off, cmp_bandgap_select, cpu_global_irq_enable;
  logic        cmp_pos_pin_digital, cmp_neg_pin_digital, pos_pin_buffer_off, neg_pin_buffer_off;
  logic        cmp_pos_port_in, cmp_neg_port_in, cmp_irq_vector_ack, cmp_irq_request;
  logic        timer_capture_src;
  logic [1:0]  m;
  int          pos_mv, neg_mv, fail_count, n_tests;
  always #2 pclk = ~pclk;
  ccirq_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .cmp_core_out, .cmp_power_off, .cmp_bandgap_select,
    .cmp_pos_pin_digital, .cmp_neg_pin_digital, .pos_pin_buffer_off, .neg_pin_buffer_off,
    .cmp_pos_port_in, .cmp_neg_port_in, .cpu_global_irq_enable, .cmp_irq_vector_ack,
    .cmp_irq_request, .irq, .timer_capture_src);
  ccirq_core_model core_u (.cmp_power_off, .cmp_bandgap_select, .pos_mv, .neg_mv,
    .cmp_core_out);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic ckb(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask : ckb
  task automatic step(input int k);
    repeat (k) @(posedge pclk);
  endtask : step
  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    step(5000);
    $display("FAIL t=%0t run not finished got=%h exp=%h", $time, 1'b0, 1'b1);
    fail_count++;
    report_and_stop();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cmp_pos_pin_digital, cmp_neg_pin_digital} = 2'h3;
    {cpu_global_irq_enable, cmp_irq_vector_ack} = 2'h0;
    pos_mv = 500;
    neg_mv = 1000;
    fail_count = 0;
    n_tests = 0;
    step(12);
    presetn <= 1'b1;
    rdc(CS, 32'h0);
    rdc(PD, 32'h0);
    rdc(IS, 32'h0);
    rdc(IM, 32'h0);
    $display("reset test done");
    apb(1'b1, CS, 32'h01);
    pos_mv <= 1500;
    step(4);
    rdc(CS, 32'h21);
    apb(1'b1, CS, 32'h01);
    rdc(CS, 32'h21);
    pos_mv <= 500;
    apb(1'b1, CS, 32'h41);
    step(4);
    ckb(cmp_bandgap_select, 1'b1);
    rdc(CS, 32'h61);
    apb(1'b1, CS, 32'hc1);
    step(4);
    ckb(cmp_power_off, 1'b1);
    rdc(CS, 32'hc1);
    rdc(IS, 32'h2);
    apb(1'b1, IM, 32'h2);
    step(2);
    ckb(irq, 1'b1);
    apb(1'b1, IM, 32'h0);
    step(2);
    ckb(irq, 1'b0);
    apb(1'b1, CS, 32'h01);
    apb(1'b1, IS, 32'h3);
    rdc(IS, 32'h0);
    $display("power test done");
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      apb(1'b1, CS, {27'h0, 1'b1, 2'h0, m});
      pos_mv <= 1500;
      step(5);
      rdc(CS, {26'h0, 1'b1, (m == 2'h0 || m == 2'h3), 2'h0, m});
      apb(1'b1, CS, {27'h0, 1'b1, 2'h0, m});
      pos_mv <= 500;
      step(5);
      rdc(CS, {27'h0, (m == 2'h0 || m == 2'h2), 2'h0, m});
    end
    $display("mode test done");
    cpu_global_irq_enable <= 1'b1;
    apb(1'b1, CS, 32'h0b);
    pos_mv <= 1500;
    step(6);
    ckb(cmp_irq_request, 1'b1);
    cpu_global_irq_enable <= 1'b0;
    step(2);
    ckb(cmp_irq_request, 1'b0);
    cpu_global_irq_enable <= 1'b1;
    cmp_irq_vector_ack <= 1'b1;
    step(1);
    cmp_irq_vector_ack <= 1'b0;
    step(3);
    ckb(cmp_irq_request, 1'b0);
    rdc(CS, 32'h2b);
    apb(1'b1, CS, 32'h03);
    pos_mv <= 500;
    step(4);
    pos_mv <= 1500;
    step(5);
    ckb(cmp_irq_request, 1'b0);
    rdc(CS, 32'h33);
    apb(1'b1, CS, 32'h13);
    rdc(CS, 32'h23);
    apb(1'b1, CS, 32'h07);
    step(2);
    ckb(timer_capture_src, 1'b1);
    pos_mv <= 500;
    step(4);
    ckb(timer_capture_src, 1'b0);
    pos_mv <= 1500;
    apb(1'b1, CS, 32'h03);
    step(4);
    ckb(timer_capture_src, 1'b0);
    ckb(cmp_pos_port_in, 1'b1);
    apb(1'b1, PD, 32'h1);
    step(2);
    ckb(cmp_pos_port_in, 1'b0);
    ckb(cmp_neg_port_in, 1'b1);
    apb(1'b1, PD, 32'h3);
    step(2);
    ckb(cmp_neg_port_in, 1'b0);
    rdc(PD, 32'h3);
    ckb(pos_pin_buffer_off, 1'b1);
    ckb(neg_pin_buffer_off, 1'b1);
    rdc(IS, 32'h1);
    apb(1'b1, IM, 32'h1);
    step(2);
    ckb(irq, 1'b1);
    apb(1'b1, IS, 32'h1);
    step(2);
    ckb(irq, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    ckb(err, 1'b1);
    $display("irq, capture and pin tests done");
    report_and_stop();
  end
endmodule : ccirq_top_tb
`default_nettype wire
